// ---- rtl/pcs_clock_gpio.sv ----
// Operation
// - Every PWM cycle keeps low side on for sixteen oscillator periods.
// - Duty ceiling per divider: 47,64,72,77,80,83,85 percent.
// - Duty reaching its limit is clamped there and not exceeded.
// - Starts on internal clock even when external clock is configured.
// - Switch to external clock only if its frequency lies in window.
// - Without an in-window external clock, keep the internal clock.
// - With fall-back enabled, a failing external clock returns to internal.
// - Master drives forwarded clock and sync pins after configuration loads.
// - Slave runs internal until configuration loads, then takes master clock.
// - Reference feeds both units, or master forwards clock and sync.
// - Channel starts offset by multiples of 90 or 120 degrees.
// - Six polarity bits invert pins 0 to 5 individually.
// - In serial-bus mode polarity of pins 5 and 4 is ignored.
// - Rail-enable pin switches its assigned rails; host may too.
// - Power-good pin asserts only when all assigned rails are good.
// - Fault pin signals one selected fault or warning source.
// - Pin functions load from one-time bits or are bus writable.
// - Frequency setting: oscillator in bits 6..4, divider in 2..0.
`timescale 1ns/1ps
module pcs_clock_gpio
(
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                arst_n,
    // Register bus
    input  wire pcs_pkg::pcs_wbreq_s wbReq,
    output pcs_pkg::pcs_wbrsp_s      wbRsp,
    // Configuration memory
    input  wire logic                cfgLoaded,
    input  wire logic [17:0]         otpPinCfg,
    // Pins
    input  wire logic [5:0]          pinIn,
    output logic [5:0]               pinOut,
    output logic [5:0]               pinOe,
    // Rail status
    input  wire logic [4:0]          powerGood,
    input  wire pcs_pkg::pcs_fault_s faults,
    // Duty path
    input  wire logic [3:0][7:0]     dutyReq,
    output logic [3:0][7:0]          dutyOut,
    // Switching control
    output logic [3:0]               chStart,
    output logic [4:0]               railEn,
    output logic                     clkSelExt
);
    import pcs_pkg::*;

    typedef struct packed {
        logic [6:0]      freq;
        logic [23:0]     sync;
        logic [8:0]      phase;
        logic [3:0][7:0] dlim;
        logic [8:0]      pol;
        logic [17:0]     pcfg;
        logic [29:0]     parg;
        logic [13:0]     ctrl;
        logic            cfgDone;
        pcs_clk_e        ckSel;
        logic [7:0]      perCnt;
        logic            clkFwd;
        logic            ack;
        logic [31:0]     rdat;
        logic [3:0][7:0] dutyOut;
        logic [3:0]      clamped;
        logic [3:0]      chStart;
        logic [5:0]      pinOut;
        logic [5:0]      pinOe;
        logic [4:0]      railEn;
    } pcs_state_s;

    // ----------------------------------------------------------------
    // Reset synchroniser
    // ----------------------------------------------------------------
    logic rstMeta;
    logic rstN;

    // Asynchronous assert, two-stage release
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rstMeta <= 1'b0;
            rstN    <= 1'b0;
        end
        else
        begin
            rstMeta <= 1'b1;
            rstN    <= rstMeta;
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    pcs_state_s st;
    pcs_state_s next_st;

    // Byte-lane merge of a bus write
    function automatic logic [31:0] mergeSel(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
            if (sel[b])
                res[b*8 +: 8] = wd[b*8 +: 8];
        return res;
    endfunction : mergeSel

    // Pins carrying a given function
    function automatic logic [5:0] fnMask(input logic [17:0] cfg, input pcs_pinfn_e fn);
        logic [5:0] m;
        m = 6'h00;
        for (int p = 0; p < NUM_PINS; p++)
            m[p] = (cfg[p*PIN_FN_W +: PIN_FN_W] == fn);
        return m;
    endfunction : fnMask

    // Start offset of a channel inside the PWM period
    function automatic logic [7:0] phOfs(input logic [1:0] ph, input logic [2:0] div,
                                         input logic three);
        logic [7:0] per;
        logic [7:0] step;
        per  = {div, 5'h00};
        step = three ? 8'(per / 8'h03) : {2'h0, per[7:2]};
        if (three && ph == 2'h3)
            return 8'h00;
        return 8'(step * {6'h00, ph});
    endfunction : phOfs

    // ----------------------------------------------------------------
    // Pin decode
    // ----------------------------------------------------------------
    logic [2:0]  divSel;
    logic [5:0]  effPol;
    logic [5:0]  pinLog;
    logic [17:0] faultVec;
    logic        clkInLvl;
    logic        extWanted;
    logic        isMaster;
    logic        syncPulse;
    logic        detValid;
    logic        detInWin;

    assign divSel    = st.freq[FREQ_DIV_LSB +: 3];
    assign effPol    = st.pol[5:0] & ~(st.pol[POL_SER_BIT] ? SER_IGNORE_MASK : 6'h00);
    assign pinLog    = pinIn ^ effPol;
    assign faultVec  = faults;
    assign clkInLvl  = |(fnMask(st.pcfg, PF_CLKIN) & pinLog);
    assign extWanted = st.sync[SYNC_EXT_BIT] | st.sync[SYNC_SLV_BIT];
    assign isMaster  = st.sync[SYNC_MST_BIT] & st.cfgDone;
    assign syncPulse = (divSel != 3'h0) && (st.perCnt == 8'h00);

    // External clock frequency window check
    pcs_freq_detect pcs_freq_detect_inst
    (
        .clk       (clk),
        .rstN      (rstN),
        .extIn     (clkInLvl),
        .refCount  (st.sync[SYNC_REF_LSB +: 8]),
        .windowPct (st.sync[SYNC_PCT_LSB +: 8]),
        .detValid  (detValid),
        .detInWin  (detInWin)
    );

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        pcs_pinfn_e fn;
        logic [4:0] arg;
        logic       fv;
        logic       oe;
        logic [4:0] railReq;
        logic [7:0] lim;
        fn      = PF_GPIN;
        arg     = 5'h00;
        fv      = 1'b0;
        oe      = 1'b0;
        railReq = 5'h00;
        lim     = 8'h00;
        next_st = st;
        next_st.ack     = 1'b0;
        next_st.chStart = 4'h0;

        // Bus answer one cycle after the request
        if (wbReq.cyc && wbReq.stb && !st.ack)
        begin
            next_st.ack = 1'b1;
            unique case (wbReq.adr)
                OFS_FREQ:  next_st.rdat = {25'h0, st.freq};
                OFS_SYNC:  next_st.rdat = {8'h00, st.sync};
                OFS_PHASE: next_st.rdat = {23'h0, st.phase};
                OFS_DLIM:  next_st.rdat = st.dlim;
                OFS_POL:   next_st.rdat = {23'h0, st.pol};
                OFS_PCFG:  next_st.rdat = {14'h0, st.pcfg};
                OFS_PARG:  next_st.rdat = {2'h0, st.parg};
                OFS_CTRL:  next_st.rdat = {18'h0, st.ctrl};
                OFS_STAT:  next_st.rdat = {3'h0, st.railEn, 2'h0, pinLog, st.clamped,
                                           2'h0, st.cfgDone, st.ckSel, 3'h0, powerGood};
                OFS_DUTY:  next_st.rdat = st.dutyOut;
                default:   next_st.rdat = 32'h0000_0000;
            endcase
        end

        // Writes take effect on the edge that sees ack
        if (wbReq.cyc && wbReq.stb && wbReq.we && st.ack)
        begin
            unique case (wbReq.adr)
                OFS_FREQ:  next_st.freq  = 7'(mergeSel({25'h0, st.freq}, wbReq.dat, wbReq.sel));
                OFS_SYNC:  next_st.sync  = 24'(mergeSel({8'h00, st.sync}, wbReq.dat, wbReq.sel));
                OFS_PHASE: next_st.phase = 9'(mergeSel({23'h0, st.phase}, wbReq.dat, wbReq.sel));
                OFS_DLIM:  next_st.dlim  = mergeSel(st.dlim, wbReq.dat, wbReq.sel);
                OFS_POL:   next_st.pol   = 9'(mergeSel({23'h0, st.pol}, wbReq.dat, wbReq.sel));
                OFS_PCFG:  next_st.pcfg  = 18'(mergeSel({14'h0, st.pcfg}, wbReq.dat, wbReq.sel));
                OFS_PARG:  next_st.parg  = 30'(mergeSel({2'h0, st.parg}, wbReq.dat, wbReq.sel));
                OFS_CTRL:  next_st.ctrl  = 14'(mergeSel({18'h0, st.ctrl}, wbReq.dat, wbReq.sel));
                default:   next_st.ctrl  = st.ctrl;
            endcase
        end

        // Configuration memory load seeds the pin functions once
        if (cfgLoaded && !st.cfgDone)
        begin
            next_st.cfgDone = 1'b1;
            next_st.pcfg    = otpPinCfg;
        end

        // Clock source selection
        unique case (st.ckSel)
            CK_INT:
            begin
                if (st.cfgDone && extWanted && detValid && detInWin)
                    next_st.ckSel = CK_EXT;
            end
            CK_EXT:
            begin
                if (!extWanted)
                    next_st.ckSel = CK_INT;
                else if (detValid && !detInWin && st.sync[SYNC_FB_BIT])
                    next_st.ckSel = CK_INT;
            end
        endcase

        // Forwarded clock runs only on a loaded master
        next_st.clkFwd = isMaster ? !st.clkFwd : 1'b0;

        // PWM period counter, divider times 32 oscillator cycles
        if (divSel == 3'h0 || st.perCnt >= ({divSel, 5'h00} - 8'h01))
            next_st.perCnt = 8'h00;
        else
            next_st.perCnt = st.perCnt + 8'h01;

        // Per-channel phase start and duty clamp
        for (int c = 0; c < 4; c++)
        begin
            next_st.chStart[c] = (divSel != 3'h0) &&
                (st.perCnt == phOfs(st.phase[c*2 +: 2], divSel, st.phase[PHASE_3PH_BIT]));
            lim = (st.dlim[c] < DUTY_MAX_TBL[divSel]) ? st.dlim[c] : DUTY_MAX_TBL[divSel];
            next_st.dutyOut[c] = (dutyReq[c] > lim) ? lim : dutyReq[c];
            next_st.clamped[c] = (dutyReq[c] >= lim);
        end

        // Pin functions
        for (int p = 0; p < NUM_PINS; p++)
        begin
            fn  = pcs_pinfn_e'(st.pcfg[p*PIN_FN_W +: PIN_FN_W]);
            arg = st.parg[p*PIN_ARG_W +: PIN_ARG_W];
            fv  = 1'b0;
            oe  = 1'b0;
            unique case (fn)
                PF_GPOUT:
                begin
                    fv = st.ctrl[CTRL_GPO_LSB + p];
                    oe = 1'b1;
                end
                PF_PGOOD:
                begin
                    fv = (arg != 5'h00) && (&(powerGood | ~arg));
                    oe = 1'b1;
                end
                PF_FAULT:
                begin
                    fv = (arg < 5'(NUM_FAULTS)) ? faultVec[arg] : 1'b0;
                    oe = 1'b1;
                end
                PF_CLKOUT:
                begin
                    fv = st.clkFwd;
                    oe = isMaster;
                end
                PF_SYNCOUT:
                begin
                    fv = syncPulse;
                    oe = isMaster;
                end
                PF_RAIL:
                begin
                    if (pinLog[p])
                        railReq = railReq | arg;
                end
                PF_GPIN, PF_CLKIN:
                begin
                    fv = 1'b0;
                end
            endcase
            next_st.pinOut[p] = fv ^ effPol[p];
            next_st.pinOe[p]  = oe;
        end
        next_st.railEn = st.ctrl[4:0] | railReq;
    end

    // State register
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            st       <= '0;
            st.freq  <= RST_FREQ;
            st.sync  <= RST_SYNC;
            st.dlim  <= {4{RST_DLIM}};
        end
        else
            st <= next_st;
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign wbRsp     = '{ack: st.ack, dat: st.rdat};
    assign pinOut    = st.pinOut;
    assign pinOe     = st.pinOe;
    assign dutyOut   = st.dutyOut;
    assign chStart   = st.chStart;
    assign railEn    = st.railEn;
    assign clkSelExt = (st.ckSel == CK_EXT);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    sequence sPhaseHit;
        (divSel != 3'h0) && (st.perCnt == phOfs(st.phase[1:0], divSel, st.phase[8]));
    endsequence

    sequence sExtGood;
        detValid && detInWin;
    endsequence

    a_start_internal: assert property (!st.cfgDone |-> !clkSelExt)
        else $error("External clock used before configuration loaded");
    a_switch_window: assert property ($rose(clkSelExt) |-> $past(detValid && detInWin))
        else $error("Switched to external clock without in-window result");
    a_switch_taken: assert property ((!clkSelExt && st.cfgDone && extWanted) ##0 sExtGood
                                     |=> clkSelExt)
        else $error("In-window external clock not taken");
    a_stay_internal: assert property (!clkSelExt && !(detValid && detInWin) |=> !clkSelExt)
        else $error("Left internal clock without in-window detection");
    a_fall_back: assert property (clkSelExt && detValid && !detInWin && st.sync[1]
                                  |=> !clkSelExt)
        else $error("Fall-back to internal clock missing");
    a_duty_clamp: assert property (1'b1 |=> dutyOut[0] <= $past(DUTY_MAX_TBL[divSel])
                                   && dutyOut[0] <= $past(st.dlim[0]))
        else $error("Duty exceeds its limit");
    a_phase_start: assert property (sPhaseHit |=> chStart[0])
        else $error("Channel start missed its phase offset");
    a_master_drive: assert property (isMaster && st.pcfg[2:0] == PF_CLKOUT
                                     |=> pinOe[0] ##1 pinOe[0] || !isMaster)
        else $error("Master clock pin not driven");
    a_pin_polarity: assert property (st.pcfg[2:0] == PF_GPOUT
                                     |=> pinOut[0] == $past(st.ctrl[8] ^ effPol[0]))
        else $error("Output polarity wrong");
    a_host_rail: assert property (st.ctrl[0] |=> railEn[0])
        else $error("Host rail enable ignored");

endmodule : pcs_clock_gpio

// ---- rtl/pcs_pkg.sv ----
package pcs_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_FREQ  = 8'h00;
    localparam logic [7:0] OFS_SYNC  = 8'h04;
    localparam logic [7:0] OFS_PHASE = 8'h08;
    localparam logic [7:0] OFS_DLIM  = 8'h0C;
    localparam logic [7:0] OFS_POL   = 8'h10;
    localparam logic [7:0] OFS_PCFG  = 8'h14;
    localparam logic [7:0] OFS_PARG  = 8'h18;
    localparam logic [7:0] OFS_CTRL  = 8'h1C;
    localparam logic [7:0] OFS_STAT  = 8'h20;
    localparam logic [7:0] OFS_DUTY  = 8'h24;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int FREQ_DIV_LSB   = 0;   // Clock divider [2:0]
    localparam int FREQ_OSC_LSB   = 4;   // Oscillator select [6:4]
    localparam int SYNC_EXT_BIT   = 0;
    localparam int SYNC_FB_BIT    = 1;
    localparam int SYNC_MST_BIT   = 2;
    localparam int SYNC_SLV_BIT   = 3;
    localparam int SYNC_PCT_LSB   = 8;
    localparam int SYNC_REF_LSB   = 16;
    localparam int PHASE_3PH_BIT  = 8;
    localparam int POL_SER_BIT    = 8;
    localparam int CTRL_GPO_LSB   = 8;
    localparam int STAT_CLK_BIT   = 8;
    localparam int STAT_DONE_BIT  = 9;
    localparam int STAT_CLMP_LSB  = 12;
    localparam int STAT_PIN_LSB   = 16;
    localparam int STAT_RAIL_LSB  = 24;
    localparam int PIN_FN_W       = 3;
    localparam int PIN_ARG_W      = 5;
    localparam int NUM_PINS       = 6;
    localparam int NUM_FAULTS     = 18;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [6:0]  RST_FREQ = 7'h01;   // 48 MHz oscillator, divide by one
    localparam logic [23:0] RST_SYNC = 24'h800500;
    localparam logic [7:0]  RST_DLIM = 8'h2F;   // 47 percent
    localparam logic [5:0]  SER_IGNORE_MASK = 6'h30;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 125_000_000;
    localparam int          SAMPLE_CYC = 16;    // Low-side current sampling time
    localparam logic [7:0]  GATE_LAST  = 8'hFF; // Detector gate of 256 cycles

    // Largest duty in percent, indexed by clock divider; leaves SAMPLE_CYC
    // oscillator periods of low-side on time every cycle
    localparam logic [7:0][7:0] DUTY_MAX_TBL =
        {8'h55, 8'h53, 8'h50, 8'h4D, 8'h48, 8'h40, 8'h2F, 8'h00};

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PF_GPIN    = 3'b000,
        PF_GPOUT   = 3'b001,
        PF_RAIL    = 3'b010,
        PF_PGOOD   = 3'b011,
        PF_FAULT   = 3'b100,
        PF_CLKIN   = 3'b101,
        PF_CLKOUT  = 3'b110,
        PF_SYNCOUT = 3'b111
    } pcs_pinfn_e;

    typedef enum logic {
        CK_INT = 1'b0,
        CK_EXT = 1'b1
    } pcs_clk_e;

    typedef struct packed {
        logic       otWarn;
        logic       otFault;
        logic [1:0] uvloWarn;
        logic [1:0] uvloFault;
        logic [3:0] ovpFault;
        logic [3:0] ocpWarn;
        logic [3:0] ocpFault;
    } pcs_fault_s;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } pcs_wbreq_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } pcs_wbrsp_s;

endpackage : pcs_pkg

// ---- rtl/pcs_freq_detect.sv ----
`timescale 1ns/1ps
module pcs_freq_detect
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstN,
    // Clock candidate and window setup
    input  wire logic       extIn,
    input  wire logic [7:0] refCount,
    input  wire logic [7:0] windowPct,
    // Verdict
    output logic            detValid,
    output logic            detInWin
);
    import pcs_pkg::*;

    typedef struct packed {
        logic       prev;
        logic [7:0] gate;
        logic [7:0] edges;
        logic       valid;
        logic       inWin;
    } pcs_det_s;

    pcs_det_s st;
    pcs_det_s next_st;

    // Edge count within tolerance of the reference count
    function automatic logic winOk(input logic [7:0] cnt, input logic [7:0] refCnt,
                                   input logic [7:0] pct);
        logic [7:0] diff;
        diff = (cnt > refCnt) ? cnt - refCnt : refCnt - cnt;
        return (16'(diff) * 16'h0064) <= (16'(refCnt) * 16'(pct));
    endfunction : winOk

    // Count rising edges over one gate, then judge the count
    always_comb
    begin
        next_st = st;
        next_st.prev  = extIn;
        next_st.valid = 1'b0;
        next_st.gate  = st.gate + 8'h01;
        if (extIn && !st.prev && st.edges != 8'hFF)
            next_st.edges = st.edges + 8'h01;
        if (st.gate == GATE_LAST)
        begin
            next_st.valid = 1'b1;
            next_st.inWin = winOk(st.edges, refCount, windowPct);
            next_st.edges = 8'h00;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            st <= '0;
        else
            st <= next_st;
    end

    assign detValid = st.valid;
    assign detInWin = st.inWin;

endmodule : pcs_freq_detect

// ---- verification/pcs_ext_clk.sv ----
`timescale 1ns/1ps
module pcs_ext_clk
(
    // Clock
    input  wire logic       clk,
    // Control
    input  wire logic       en,
    input  wire logic [3:0] halfPer,
    // Far-side clock
    output logic            extClk
);
    logic [3:0] cnt;

    // Source clock runs only while enabled and stands low otherwise
    always_ff @(posedge clk)
    begin
        if (!en)
        begin
            cnt    <= 4'h0;
            extClk <= 1'b0;
        end
        else if (cnt == halfPer - 4'h1)
        begin
            cnt    <= 4'h0;
            extClk <= ~extClk;
        end
        else
            cnt <= cnt + 4'h1;
    end
endmodule : pcs_ext_clk

// ---- verification/test_pwm_clock_sync_gpio_control.sv ----
`timescale 1ns/1ps
module test_pwm_clock_sync_gpio_control;
    import pcs_pkg::*;
    logic clk, arst_n, cfgLoaded, srcEn, extClk;
    pcs_wbreq_s wbReq;
    pcs_wbrsp_s wbRsp;
    logic [5:0] pins, pinOut, pinOe;
    logic [3:0][7:0] dutyReq, dutyOut;
    logic [3:0] chStart;
    logic [4:0] railEn;
    logic clkSelExt;
    logic [4:0] pg;
    pcs_fault_s flt;
    logic [31:0] rd;
    int err_total, compares;

    pcs_clock_gpio pcs_clock_gpio_inst (.clk(clk), .arst_n(arst_n), .wbReq(wbReq),
        .wbRsp(wbRsp), .cfgLoaded(cfgLoaded), .otpPinCfg(18'h00140),
        .pinIn({pins[5:3], extClk, pins[1:0]}), .pinOut(pinOut), .pinOe(pinOe),
        .powerGood(pg), .faults(flt), .dutyReq(dutyReq), .dutyOut(dutyOut),
        .chStart(chStart), .railEn(railEn), .clkSelExt(clkSelExt));
    pcs_ext_clk pcs_ext_clk_inst (.clk(clk), .en(srcEn), .halfPer(4'h4), .extClk(extClk));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task results;
    begin
        $display("checks=%0d mismatches=%0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask : results

    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        compares++;
        if (got !== exp)
        begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    end
    endtask : chk

    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
    begin
        @(posedge clk);
        wbReq <= '{1'b1, 1'b1, w, 4'hF, a, d};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wbRsp.ack !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            err_total++;
            results();
        end
        rd = wbRsp.dat;
        wbReq.cyc <= 1'b0;
        wbReq.stb <= 1'b0;
    end
    endtask : wb

    // Wait for the clock select to reach a level, bounded
    task waitSel(input logic lvl);
        int n;
    begin
        for (n = 0; n < 1500 && clkSelExt !== lvl; n++)
            @(posedge clk);
        chk(clkSelExt, lvl);
    end
    endtask : waitSel

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task testClock;
    begin
        wb(0, OFS_FREQ, 0); chk(rd, 32'h01);
        wb(0, OFS_SYNC, 0); chk(rd, 32'h800500);
        wb(0, 8'hFC, 0); chk(rd, 32'h0);
        wb(1, OFS_SYNC, 32'h200A03);
        srcEn <= 1'b1;
        repeat (600) @(posedge clk);
        chk(clkSelExt, 1'b0);
        cfgLoaded <= 1'b1;
        wb(0, OFS_PCFG, 0); chk(rd, 32'h140);
        waitSel(1'b1);
        srcEn <= 1'b0;
        waitSel(1'b0);
        wb(1, OFS_SYNC, 32'h200A01);
        repeat (600) @(posedge clk);
        chk(clkSelExt, 1'b0);
        $display("clock test done");
    end
    endtask : testClock

    task testDuty;
        int n;
    begin
        wb(0, OFS_DLIM, 0); chk(rd, 32'h2F2F2F2F);
        wb(1, OFS_FREQ, 32'h07);
        wb(1, OFS_DLIM, 32'h60606010);
        dutyReq <= {8'h64, 8'h64, 8'h10, 8'h64};
        repeat (2) @(posedge clk);
        chk(dutyOut, {8'h55, 8'h55, 8'h10, 8'h10});
        wb(1, OFS_FREQ, 32'h01);
        repeat (2) @(posedge clk);
        chk(dutyOut[3], 8'h2F);
        wb(1, OFS_DLIM, 32'h2F2F2F2F);
        wb(1, OFS_PHASE, 32'h8);
        repeat (2) @(posedge clk);
        for (n = 0; n < 64 && chStart[0] !== 1'b1; n++)
            @(posedge clk);
        for (n = 0; n < 64 && chStart[1] !== 1'b1; n++)
            @(posedge clk);
        chk(n, 16);
        $display("duty test done");
    end
    endtask : testDuty

    task testPins;
    begin
        wb(1, OFS_PCFG, 32'h1151);
        wb(1, OFS_PARG, 32'hA0);
        wb(1, OFS_CTRL, 32'h1100);
        repeat (2) @(posedge clk);
        chk({pinOe[4], pinOe[0], pinOut[4], pinOut[0]}, 4'hF);
        wb(1, OFS_POL, 32'h011);
        repeat (2) @(posedge clk);
        chk({pinOut[4], pinOut[0]}, 2'b00);
        wb(1, OFS_POL, 32'h111);
        repeat (2) @(posedge clk);
        chk({pinOut[4], pinOut[0]}, 2'b10);
        pins[1] <= 1'b1;
        repeat (2) @(posedge clk);
        chk(railEn, 5'h05);
        pins[1] <= 1'b0;
        repeat (2) @(posedge clk);
        chk(railEn, 5'h00);
        wb(1, OFS_PCFG, 32'h21756);
        wb(1, OFS_PARG, 32'h100180A0);
        wb(1, OFS_SYNC, 32'h200A04);
        pg <= 5'h1D;
        repeat (2) @(posedge clk);
        chk({pinOe[0], pinOut[5], pinOut[3]}, 3'b100);
        pg <= 5'h1F;
        flt <= 18'h00100;
        repeat (2) @(posedge clk);
        chk({pinOut[5], pinOut[3]}, 2'b11);
        $display("pin test done");
    end
    endtask : testPins

    // ----------------------------------------------------------------
    // Clock, reset and sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        arst_n = 1'b0;
        cfgLoaded = 1'b0;
        srcEn = 1'b0;
        wbReq = '0;
        pins = 6'h00;
        dutyReq = '0;
        pg = 5'h1F;
        flt = '0;
        err_total = 0;
        compares = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        testClock();
        testDuty();
        testPins();
        results();
    end
endmodule : test_pwm_clock_sync_gpio_control
